// File: inc/sfw_pkg.sv
// Purpose: shared constants and types for the serial flash wake/hold link
// Assumes: CLK runs at 125 MHz on both ends
// Notes: times are kept in their own unit and turned into cycle counts here
package sfw_pkg;

    // Opcode that brings the device out of deep power-down
    localparam logic [7:0] OP_WAKE = 8'hAB;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_RESUME_DELAY_NS = 30000; // longest resume time
    localparam int WAKE_RESUME_CYC = WAKE_RESUME_DELAY_NS / CLK_PERIOD_NS; // rounds down
    localparam int SYNC_LAG_CYC = 3; // pin edge to registered reaction
    localparam int CS_HIGH_NS = 50; // least chip select high time
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS = 64; // half period of the generated link clock
    localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;

    // Counters
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [CNT_W-1:0] WAKE_RESUME_LOAD = CNT_W'(WAKE_RESUME_CYC - SYNC_LAG_CYC);
    localparam logic [CNT_W-1:0] SELF_TIMED_LOAD = 12'h400; // length of a self-timed op
    localparam logic [3:0] HALF_ZERO = 4'h0;
    localparam logic [3:0] HALF_ONE = 4'h1;
    localparam logic [3:0] SCK_HALF_LOAD = 4'(SCK_HALF_CYC - 1);
    localparam logic [3:0] CS_GAP_LOAD = 4'(CS_HIGH_CYC - 1);
    localparam logic [2:0] BIT_ZERO = 3'h0;
    localparam logic [2:0] BIT_ONE = 3'h1;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Device pin synchroniser layout
    localparam int SYNC_W = 5;
    localparam int IX_CS = 4;
    localparam int IX_SCK = 3;
    localparam int IX_SI = 2;
    localparam int IX_HOLD = 1;
    localparam int IX_WP = 0;
    localparam logic [SYNC_W-1:0] SYNC_INIT = 5'h13; // cs_n, hold_n, wp_n idle high

    typedef enum logic [2:0] {
        ST_STANDBY = 3'h1,
        ST_DPD = 3'h2,
        ST_RESUME = 3'h4
    } sfw_dev_state_t;

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_SETUP = 5'h02,
        H_XFER = 5'h04,
        H_NEXT = 5'h08,
        H_GAP = 5'h10
    } sfw_host_state_t;

endpackage

// File: inc/sfw_link_if.sv
// Purpose: serial link between host controller and flash end
// Assumes: the flash end is the only driver of the serial output
// Notes: a floating serial output is seen as low on so_line
`timescale 1ns/1ns
`default_nettype none
interface sfw_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic so;
    logic so_oe_n;
    logic so_line;

    // Wire level from the output enable
    assign so_line = so & ~so_oe_n;

    modport dev (
        input cs_n,
        input sck,
        input si,
        input hold_n,
        input wp_n,
        output so,
        output so_oe_n
    );

    modport host (
        output cs_n,
        output sck,
        output si,
        output hold_n,
        output wp_n,
        input so_line
    );
endinterface
`default_nettype wire

// File: src/sfw_sync.sv
// Purpose: two-flop synchroniser with edge flags on the settled value
// Assumes: inputs are asynchronous to clk
// Notes: edges are taken from stages two and three only
`timescale 1ns/1ns
`default_nettype none
module sfw_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = {W{1'b0}}
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] q_d,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_reg, s1_next;
    logic [W-1:0] s2_reg, s2_next;
    logic [W-1:0] s3_reg, s3_next;

    // Shift chain; first stage feeds only the second
    always_comb begin
        s1_next = d;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
        end
    end

    // Settled value, its previous sample and the edges between them
    assign q = s2_reg;
    assign q_d = s3_reg;
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;
endmodule // sfw_sync
`default_nettype wire

// File: src/sfw_dev.sv
// Purpose: flash end of the link: wake from deep power-down, hold, edge timing
// Assumes: link pins are asynchronous and pass the synchroniser first
// Notes: commands other than wake are handed to the user side byte by byte
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Deep power-down ignores everything but wake
// - Host wakes with chip select, wake opcode
// - Whole bytes after the wake opcode are ignored
// - Chip select rise after wake starts resume
// - Partial or unaligned wake keeps deep power-down
// - Hold never pauses self-timed operations
// - Hold starts only in clock low phase
// - Hold lasts while hold and select asserted
// - Hold floats output, ignores input, keeps protect
// - Hold ends only in clock low phase
// - Select rise during hold aborts, clears latch
// - Drive on falling edge, sample on rising
// - Full-cycle host samples on next falling
// - Full-cycle host drives on rising edge
// - Mode 0/3 host samples next rising edge
// - Standby reached within 30 us of wake
module sfw_dev (
    input wire logic CLK,
    input wire logic RST,
    sfw_link_if.dev LNK,
    input wire logic DPD_ENTER,
    input wire logic LATCH_SET,
    input wire logic OP_START,
    input wire logic [7:0] TX_BYTE,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic IN_DPD,
    output logic RESUMING,
    output logic WRITE_ENABLE_LATCH,
    output logic HOLD_ACTIVE,
    output logic OP_BUSY,
    output logic WP_ACTIVE
);
    logic [sfw_pkg::SYNC_W-1:0] pin_q;
    logic [sfw_pkg::SYNC_W-1:0] pin_q_d;
    logic [sfw_pkg::SYNC_W-1:0] pin_rise;
    logic [sfw_pkg::SYNC_W-1:0] pin_fall;
    logic cs_act;
    logic cs_end;
    logic sck_high;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    logic hold_pin;
    logic link_live;
    logic byte_done;
    logic [7:0] byte_in;
    sfw_pkg::sfw_dev_state_t state_reg, state_next;
    logic hold_reg, hold_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic first_reg, first_next;
    logic wake_reg, wake_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic tx_en_reg, tx_en_next;
    logic so_reg, so_next;
    logic oe_n_reg, oe_n_next;
    logic [7:0] rx_byte_reg, rx_byte_next;
    logic rx_valid_reg, rx_valid_next;
    logic [sfw_pkg::CNT_W-1:0] rsm_cnt_reg, rsm_cnt_next;
    logic [sfw_pkg::CNT_W-1:0] op_cnt_reg, op_cnt_next;
    logic write_enable_latch_reg, write_enable_latch_next;
    logic wp_reg, wp_next;

    // All link pins cross into CLK here
    sfw_sync #(
        .W(sfw_pkg::SYNC_W),
        .INIT(sfw_pkg::SYNC_INIT)
    ) u_pins (
        .clk(CLK),
        .rst(RST),
        .d({LNK.cs_n, LNK.sck, LNK.si, LNK.hold_n, LNK.wp_n}),
        .q(pin_q),
        .q_d(pin_q_d),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Decoded pin events
    assign cs_act = ~pin_q[sfw_pkg::IX_CS];
    assign cs_end = pin_rise[sfw_pkg::IX_CS];
    assign sck_high = pin_q[sfw_pkg::IX_SCK];
    assign sck_rise = pin_rise[sfw_pkg::IX_SCK];
    assign sck_fall = pin_fall[sfw_pkg::IX_SCK];
    assign si_bit = pin_q_d[sfw_pkg::IX_SI]; // value before the edge; host may change it on it
    assign hold_pin = ~pin_q[sfw_pkg::IX_HOLD];
    assign link_live = cs_act & ~hold_reg;
    assign byte_in = {rx_sh_reg[6:0], si_bit};
    assign byte_done = link_live & sck_rise & (bit_reg == sfw_pkg::BIT_LAST);

    // Hold tracking; hold pin changes take effect only in the clock low phase, deselect clears at once
    always_comb begin
        hold_next = hold_reg;
        if (!cs_act) begin
            hold_next = 1'b0;
        end else if (!hold_reg) begin
            hold_next = hold_pin & ~sck_high;
        end else begin
            hold_next = hold_pin | sck_high;
        end
    end

    // Shift in on rising, shift out on falling
    always_comb begin
        bit_next = bit_reg;
        rx_sh_next = rx_sh_reg;
        first_next = first_reg;
        wake_next = wake_reg;
        tx_sh_next = tx_sh_reg;
        tx_en_next = tx_en_reg;
        so_next = so_reg;
        rx_byte_next = rx_byte_reg;
        rx_valid_next = 1'b0;
        if (cs_end) begin
            bit_next = sfw_pkg::BIT_ZERO;
            first_next = 1'b0;
            wake_next = 1'b0;
            tx_en_next = 1'b0;
        end else if (link_live && sck_rise) begin
            bit_next = bit_reg + sfw_pkg::BIT_ONE;
            rx_sh_next = byte_in;
            if (byte_done) begin
                first_next = 1'b1;
                if (state_reg == sfw_pkg::ST_DPD) begin
                    // Only the first byte counts as opcode
                    if (!first_reg) begin
                        wake_next = (byte_in == sfw_pkg::OP_WAKE);
                    end
                end else if (state_reg == sfw_pkg::ST_STANDBY) begin
                    rx_byte_next = byte_in;
                    rx_valid_next = 1'b1;
                    tx_sh_next = TX_BYTE;
                    tx_en_next = 1'b1;
                end
            end
        end else if (link_live && sck_fall && tx_en_reg) begin
            so_next = tx_sh_reg[7];
            tx_sh_next = {tx_sh_reg[6:0], 1'b0};
        end
    end

    // Output enable: floated in hold, deep power-down and outside a frame
    always_comb begin
        oe_n_next = ~(tx_en_reg & link_live & (state_reg == sfw_pkg::ST_STANDBY));
    end

    // Power state; a wake counts only on a byte boundary after a full opcode
    always_comb begin
        state_next = state_reg;
        rsm_cnt_next = rsm_cnt_reg;
        unique case (state_reg)
            sfw_pkg::ST_STANDBY: begin
                // Entry refused while a self-timed op runs
                if (DPD_ENTER && !cs_act && op_cnt_reg == sfw_pkg::CNT_ZERO) begin
                    state_next = sfw_pkg::ST_DPD;
                end
            end
            sfw_pkg::ST_DPD: begin
                if (cs_end && wake_reg && bit_reg == sfw_pkg::BIT_ZERO) begin
                    state_next = sfw_pkg::ST_RESUME;
                    rsm_cnt_next = sfw_pkg::WAKE_RESUME_LOAD;
                end
            end
            sfw_pkg::ST_RESUME: begin
                if (rsm_cnt_reg == sfw_pkg::CNT_ONE) begin
                    state_next = sfw_pkg::ST_STANDBY;
                end else begin
                    rsm_cnt_next = rsm_cnt_reg - sfw_pkg::CNT_ONE;
                end
            end
        endcase
    end

    // Self-timed op, write-enable latch and protect pin
    always_comb begin
        op_cnt_next = op_cnt_reg;
        if (op_cnt_reg != sfw_pkg::CNT_ZERO) begin
            op_cnt_next = op_cnt_reg - sfw_pkg::CNT_ONE;
        end else if (OP_START && state_reg == sfw_pkg::ST_STANDBY) begin
            op_cnt_next = sfw_pkg::SELF_TIMED_LOAD;
        end
        write_enable_latch_next = write_enable_latch_reg;
        if (cs_end && (hold_reg || hold_pin)) begin
            write_enable_latch_next = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (LATCH_SET && state_reg == sfw_pkg::ST_STANDBY) begin
            write_enable_latch_next = 1'b1;
        end
        wp_next = ~pin_q[sfw_pkg::IX_WP];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= sfw_pkg::ST_STANDBY;
            hold_reg <= 1'b0;
            bit_reg <= sfw_pkg::BIT_ZERO;
            rx_sh_reg <= 8'h00;
            first_reg <= 1'b0;
            wake_reg <= 1'b0;
            tx_sh_reg <= 8'h00;
            tx_en_reg <= 1'b0;
            so_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            rx_byte_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            rsm_cnt_reg <= sfw_pkg::CNT_ZERO;
            op_cnt_reg <= sfw_pkg::CNT_ZERO;
            write_enable_latch_reg <= 1'b0;
            wp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_reg <= hold_next;
            bit_reg <= bit_next;
            rx_sh_reg <= rx_sh_next;
            first_reg <= first_next;
            wake_reg <= wake_next;
            tx_sh_reg <= tx_sh_next;
            tx_en_reg <= tx_en_next;
            so_reg <= so_next;
            oe_n_reg <= oe_n_next;
            rx_byte_reg <= rx_byte_next;
            rx_valid_reg <= rx_valid_next;
            rsm_cnt_reg <= rsm_cnt_next;
            op_cnt_reg <= op_cnt_next;
            write_enable_latch_reg <= write_enable_latch_next;
            wp_reg <= wp_next;
        end
    end

    // Pins and status
    assign LNK.so = so_reg;
    assign LNK.so_oe_n = oe_n_reg;
    assign RX_BYTE = rx_byte_reg;
    assign RX_VALID = rx_valid_reg;
    assign IN_DPD = (state_reg == sfw_pkg::ST_DPD);
    assign RESUMING = (state_reg == sfw_pkg::ST_RESUME);
    assign WRITE_ENABLE_LATCH = write_enable_latch_reg;
    assign HOLD_ACTIVE = hold_reg;
    assign OP_BUSY = (op_cnt_reg != sfw_pkg::CNT_ZERO);
    assign WP_ACTIVE = wp_reg;
endmodule // sfw_dev
`default_nettype wire

// File: src/sfw_host.sv
// Purpose: host controller end: makes the link clock, shifts bytes, drives hold
// Assumes: one command byte is offered at a time on the user side
// Notes: the response byte returned with a command is what the device sent meanwhile
`timescale 1ns/1ns
`default_nettype none
module sfw_host (
    input wire logic CLK,
    input wire logic RST,
    sfw_link_if.host LNK,
    input wire logic FULL_CYCLE,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_BYTE,
    input wire logic CMD_LAST,
    output logic CMD_READY,
    input wire logic HOLD_REQ,
    input wire logic ABORT,
    input wire logic WP_REQ,
    output logic [7:0] RSP_BYTE,
    output logic RSP_VALID,
    output logic BUSY
);
    logic so_s;
    logic tick;
    logic rise_ev;
    logic fall_ev;
    logic act;
    logic [7:0] rx_in;
    sfw_pkg::sfw_host_state_t state_reg, state_next;
    logic [3:0] half_reg, half_next;
    logic sck_reg, sck_next;
    logic cs_n_reg, cs_n_next;
    logic si_reg, si_next;
    logic hold_reg, hold_next;
    logic wp_reg, wp_next;
    logic last_reg, last_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic [7:0] rsp_reg, rsp_next;
    logic rsp_valid_reg, rsp_valid_next;

    // Serial output crosses in through two flops
    sfw_sync #(
        .W(1),
        .INIT(1'h0)
    ) u_so (
        .clk(CLK),
        .rst(RST),
        .d(LNK.so_line),
        .q(so_s),
        .q_d(),
        .rise(),
        .fall()
    );

    // Divider ticks and edge events; the clock keeps running during hold
    assign tick = (half_reg == sfw_pkg::HALF_ZERO);
    assign rise_ev = (state_reg == sfw_pkg::H_XFER) & tick & ~sck_reg;
    assign fall_ev = (state_reg == sfw_pkg::H_XFER) & tick & sck_reg;
    assign act = ~hold_reg;
    assign rx_in = {rx_sh_reg[6:0], so_s};

    // Frame sequencing
    always_comb begin
        state_next = state_reg;
        half_next = tick ? sfw_pkg::SCK_HALF_LOAD : half_reg - sfw_pkg::HALF_ONE;
        sck_next = sck_reg;
        cs_n_next = cs_n_reg;
        si_next = si_reg;
        hold_next = hold_reg;
        wp_next = WP_REQ;
        last_next = last_reg;
        bit_next = bit_reg;
        tx_sh_next = tx_sh_reg;
        rx_sh_next = rx_sh_reg;
        rsp_next = rsp_reg;
        rsp_valid_next = 1'b0;
        unique case (state_reg)
            sfw_pkg::H_IDLE, sfw_pkg::H_NEXT: begin
                half_next = sfw_pkg::SCK_HALF_LOAD;
                if (CMD_VALID) begin
                    // First bit is on the line before the first rising edge
                    cs_n_next = 1'b0;
                    tx_sh_next = CMD_BYTE;
                    si_next = CMD_BYTE[7];
                    last_next = CMD_LAST;
                    bit_next = sfw_pkg::BIT_ZERO;
                    if (state_reg == sfw_pkg::H_IDLE) begin
                        state_next = sfw_pkg::H_SETUP;
                    end else begin
                        state_next = sfw_pkg::H_XFER;
                    end
                end
            end
            sfw_pkg::H_SETUP: begin
                if (tick) begin
                    state_next = sfw_pkg::H_XFER;
                end
            end
            sfw_pkg::H_XFER: begin
                if (tick) begin
                    sck_next = ~sck_reg;
                end
                if (rise_ev && act) begin
                    if (!FULL_CYCLE) begin
                        rx_sh_next = rx_in;
                    end else if (bit_reg != sfw_pkg::BIT_LAST) begin
                        si_next = tx_sh_reg[6];
                        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                    end
                end
                if (fall_ev) begin
                    hold_next = HOLD_REQ; // changes only as the low phase starts
                    if (act) begin
                        bit_next = bit_reg + sfw_pkg::BIT_ONE;
                        if (FULL_CYCLE) begin
                            rx_sh_next = rx_in;
                        end else if (bit_reg != sfw_pkg::BIT_LAST) begin
                            si_next = tx_sh_reg[6];
                            tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                        end
                        if (bit_reg == sfw_pkg::BIT_LAST) begin
                            rsp_next = FULL_CYCLE ? rx_in : rx_sh_reg;
                            rsp_valid_next = 1'b1;
                            hold_next = 1'b0;
                            cs_n_next = last_reg;
                            if (last_reg) begin
                                state_next = sfw_pkg::H_GAP;
                                half_next = sfw_pkg::CS_GAP_LOAD;
                            end else begin
                                state_next = sfw_pkg::H_NEXT;
                            end
                        end
                    end
                end
            end
            sfw_pkg::H_GAP: begin
                if (tick) begin
                    state_next = sfw_pkg::H_IDLE;
                end
            end
        endcase
        // Abort lifts select at once, hold or not, mid-byte or not
        if (ABORT && !cs_n_reg) begin
            state_next = sfw_pkg::H_GAP;
            cs_n_next = 1'b1;
            sck_next = 1'b0;
            hold_next = 1'b0;
            half_next = sfw_pkg::CS_GAP_LOAD;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= sfw_pkg::H_IDLE;
            half_reg <= sfw_pkg::SCK_HALF_LOAD;
            sck_reg <= 1'b0;
            cs_n_reg <= 1'b1;
            si_reg <= 1'b0;
            hold_reg <= 1'b0;
            wp_reg <= 1'b0;
            last_reg <= 1'b0;
            bit_reg <= sfw_pkg::BIT_ZERO;
            tx_sh_reg <= 8'h00;
            rx_sh_reg <= 8'h00;
            rsp_reg <= 8'h00;
            rsp_valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            half_reg <= half_next;
            sck_reg <= sck_next;
            cs_n_reg <= cs_n_next;
            si_reg <= si_next;
            hold_reg <= hold_next;
            wp_reg <= wp_next;
            last_reg <= last_next;
            bit_reg <= bit_next;
            tx_sh_reg <= tx_sh_next;
            rx_sh_reg <= rx_sh_next;
            rsp_reg <= rsp_next;
            rsp_valid_reg <= rsp_valid_next;
        end
    end

    // Pins and user side
    assign LNK.cs_n = cs_n_reg;
    assign LNK.sck = sck_reg;
    assign LNK.si = si_reg;
    assign LNK.hold_n = ~hold_reg;
    assign LNK.wp_n = ~wp_reg;
    assign CMD_READY = (state_reg == sfw_pkg::H_IDLE) | (state_reg == sfw_pkg::H_NEXT);
    assign RSP_BYTE = rsp_reg;
    assign RSP_VALID = rsp_valid_reg;
    assign BUSY = (state_reg != sfw_pkg::H_IDLE);
endmodule // sfw_host
`default_nettype wire

// File: bench/sfw_link_props.sv
// Purpose: link timing checks on the wires between host and flash ends
// Assumes: both ends share CLK; RST synchronous, active high
// Notes: the flash end sees pins about three cycles late, bounds allow for it
`timescale 1ns/1ns
`default_nettype none
module sfw_link_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic hold_n,
    input wire logic so,
    input wire logic so_oe_n
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // Link clock parks low outside frames
    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("link clock high while deselected");
    // High phases last eight cycles unless select lifts, low phases at least eight, so edges stay apart
    AST_SCK_HIGH: assert property ($rose(sck) |-> (sck || cs_n)[*8] ##1 !sck)
        else $error("link clock high phase wrong length");
    AST_SCK_LOW: assert property ($fell(sck) |-> (!sck)[*8])
        else $error("link clock low phase too short");
    // Output moves only after a falling edge, never in the high phase
    AST_SO_ON_FALL: assert property ($changed(so) |-> !sck)
        else $error("serial output changed while clock high");
    // Held bus leaves the output floating
    AST_HOLD_FLOAT: assert property ((!hold_n && !cs_n)[*5] |-> so_oe_n)
        else $error("output driven during hold");
    // Deselect releases the bus and ends any transfer
    AST_DESEL_FLOAT: assert property (cs_n[*5] |-> so_oe_n)
        else $error("output driven while deselected");
    AST_HOLD_IDLE: assert property (cs_n && $past(cs_n) |-> hold_n)
        else $error("hold asserted without chip select");
    AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*7])
        else $error("chip select high time too short");
endmodule // sfw_link_props
`default_nettype wire

// File: bench/tb.sv
// Purpose: drives the host user side and checks the flash end flags
// Assumes: host and flash ends joined by one link interface
// Notes: resume wait bounded by the package resume count
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic CLK, RST, full_cycle, cmd_valid, cmd_last, cmd_ready, hold_req, abort_req, wp_req;
    logic rsp_valid, busy, dpd_enter, latch_set, op_start, rx_valid, in_dpd, resuming;
    logic write_enable_latch, hold_active, op_busy, wp_active;
    logic [7:0] cmd_byte, rsp_byte, tx_byte, rx_byte, rx_last;
    int bad_count = 0, cmp_count = 0, rx_cnt = 0;
    sfw_link_if lnk();
    sfw_host u_sfw_host (.CLK(CLK), .RST(RST), .LNK(lnk), .FULL_CYCLE(full_cycle),
        .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte), .CMD_LAST(cmd_last),
        .CMD_READY(cmd_ready), .HOLD_REQ(hold_req), .ABORT(abort_req), .WP_REQ(wp_req),
        .RSP_BYTE(rsp_byte), .RSP_VALID(rsp_valid), .BUSY(busy));
    sfw_dev u_sfw_dev (.CLK(CLK), .RST(RST), .LNK(lnk), .DPD_ENTER(dpd_enter),
        .LATCH_SET(latch_set), .OP_START(op_start), .TX_BYTE(tx_byte), .RX_BYTE(rx_byte),
        .RX_VALID(rx_valid), .IN_DPD(in_dpd), .RESUMING(resuming),
        .WRITE_ENABLE_LATCH(write_enable_latch),
        .HOLD_ACTIVE(hold_active), .OP_BUSY(op_busy), .WP_ACTIVE(wp_active));
    sfw_link_props u_sfw_link_props (.CLK(CLK), .RST(RST), .cs_n(lnk.cs_n),
        .sck(lnk.sck), .hold_n(lnk.hold_n), .so(lnk.so), .so_oe_n(lnk.so_oe_n));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Keep the last received byte; pulse lasts one cycle
    always @(posedge CLK) begin
        if (rx_valid === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            rx_last <= rx_byte;
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // One byte through the host; bounded so hold stretching still fits
    task automatic send(input logic [7:0] b, input logic last);
        int n = 0;
        cmd_byte = b;
        cmd_last = last;
        cmd_valid = 1'b1;
        do begin @(posedge CLK); n++; end while (cmd_ready !== 1'b1 && n < 2000);
        #1 cmd_valid = 1'b0;
        do begin @(posedge CLK); n++; end while (rsp_valid !== 1'b1 && n < 2000);
        #1;
        if (n >= 2000) bad_count++; // A hung byte counts as a mismatch
    endtask
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int n;
        {full_cycle, cmd_valid, cmd_last, hold_req, abort_req, wp_req} = 6'h00;
        {dpd_enter, latch_set, op_start} = 3'h0;
        cmd_byte = 8'h00;
        tx_byte = 8'hC3;
        RST = 1'b1;
        cyc(3);
        RST = 1'b0;
        cyc(4);
        // Two-byte frames in mode 0 then full-cycle timing
        for (int m = 0; m < 2; m++) begin
            full_cycle = m[0];
            n = rx_cnt;
            send(8'h5A, 1'b0);
            send(8'h3C, 1'b1);
            cyc(6);
            `CHK("rsp", 8'hC3, rsp_byte)
            `CHK("rx", 8'h3C, rx_last)
            `CHK("rx_cnt", n + 2, rx_cnt)
        end
        // Deep power-down: wake not first byte, then wake with trailing byte
        pulse(dpd_enter);
        cyc(4);
        `CHK("dpd", 1'b1, in_dpd)
        n = rx_cnt;
        send(8'h5A, 1'b0);
        send(8'hAB, 1'b1);
        cyc(10);
        `CHK("ignored", n, rx_cnt)
        `CHK("still_dpd", 1'b1, in_dpd)
        send(sfw_pkg::OP_WAKE, 1'b0);
        send(8'hFF, 1'b1);
        n = 0;
        while ((in_dpd | resuming) !== 1'b0 && n < 4000) begin
            cyc(1);
            n++;
        end
        `CHK("resume", 1'b1, n <= sfw_pkg::WAKE_RESUME_CYC)
        n = rx_cnt;
        send(8'h66, 1'b1);
        cyc(4);
        `CHK("awake_rx", n + 1, rx_cnt)
        // Hold mid-byte while a self-timed op runs and protect toggles
        pulse(latch_set);
        pulse(op_start);
        fork
            send(8'h96, 1'b1);
            begin
                cyc(40);
                hold_req = 1'b1;
                cyc(40);
                `CHK("hold", 1'b1, hold_active)
                `CHK("op_busy", 1'b1, op_busy)
                wp_req = 1'b1;
                cyc(6);
                `CHK("wp", 1'b1, wp_active)
                wp_req = 1'b0;
                hold_req = 1'b0;
                cyc(30);
                `CHK("unhold", 1'b0, hold_active)
            end
        join
        cyc(6);
        `CHK("held_rx", 8'h96, rx_last)
        `CHK("latch_kept", 1'b1, write_enable_latch)
        // Deselect while held: transfer dropped, latch cleared
        n = rx_cnt;
        cmd_byte = 8'h11;
        cmd_last = 1'b1;
        cmd_valid = 1'b1;
        cyc(1);
        cmd_valid = 1'b0;
        hold_req = 1'b1;
        cyc(40);
        pulse(abort_req);
        hold_req = 1'b0;
        cyc(20);
        `CHK("latch_clr", 1'b0, write_enable_latch)
        `CHK("idle", 1'b0, busy)
        `CHK("abort_rx", n, rx_cnt)
        end_sim();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        end_sim();
    end
endmodule // tb
`default_nettype wire
